// >>> logic/opp_port.sv
// otp parallel programming port, device side
`timescale 1ns/1ps
// How it works
// - bus_drive_n low: device drives bus; high: bus is input.
// - mode select high means mode byte; low defers to addr_not_data_sel.
// - addr_not_data_sel high is address byte, low is data byte.
// - user area is 32k words of 16 bits, addressed via port.
// - set user lock bit blocks user-area writes; set verify lock bit blocks read-back.
// - security bits are one-time; only reset clears a set bit.
// - blank device: user prog on, test prog off, verify on.
module opp_port (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [opp_pkg::BUS_W-1:0] io_i,
	output logic [opp_pkg::BUS_W-1:0] io_o,
	output logic [opp_pkg::BUS_W-1:0] io_oe_o,
	input wire logic bus_drive_n_i,
	input wire logic program_pulse_n_i,
	input wire logic mode_sel_i,
	input wire logic addr_not_data_sel_i,
	output logic mem_we_o,
	output logic mem_test_o,
	output logic [opp_pkg::ADDR_W-1:0] mem_addr_o,
	output logic [opp_pkg::WORD_W-1:0] mem_wdata_o,
	input wire logic [opp_pkg::WORD_W-1:0] mem_rdata_i,
	output logic user_lock_o,
	output logic test_open_o,
	output logic verify_lock_o
);
	import opp_pkg::*;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// bus and strobes pass two flops before any logic reads them
	logic [BUS_W+3:0] pin_s1_reg;
	logic [BUS_W+3:0] pin_s2_reg;
	// reset to idle strobe levels, so no false edge follows reset
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_s1_reg <= PIN_SYNC_RST;
			pin_s2_reg <= PIN_SYNC_RST;
		end else begin
			pin_s1_reg <= {io_i, bus_drive_n_i, program_pulse_n_i, mode_sel_i,
				addr_not_data_sel_i};
			pin_s2_reg <= pin_s1_reg;
		end
	end
	wire [BUS_W-1:0] bus_in = pin_s2_reg[BUS_W+3:4];
	wire drive_n = pin_s2_reg[3];
	wire pulse_n = pin_s2_reg[2];
	wire mode_sel = pin_s2_reg[1];
	wire adn_sel = pin_s2_reg[0];

	// ----------------------------------------
	// delayed copies for change detection
	// ----------------------------------------
	// a byte is taken once, when bus and selects settle on a new value
	logic [TURN_SETTLE_CYC-1:0] drive_hist_reg;
	logic pulse_n_d_reg;
	logic [BUS_W+1:0] cap_d_reg;
	wire [BUS_W+1:0] cap_now = {bus_in, mode_sel, adn_sel};
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			drive_hist_reg <= '1;
			pulse_n_d_reg <= 1'b1;
			cap_d_reg <= '0;
		end else begin
			drive_hist_reg <= {drive_hist_reg[TURN_SETTLE_CYC-2:0], drive_n};
			pulse_n_d_reg <= pulse_n;
			cap_d_reg <= cap_now;
		end
	end

	// ----------------------------------------
	// byte classification
	// ----------------------------------------
	// the bus must have been an input for a few cycles, so our own
	// stale output byte is never read back as a new byte
	wire bus_input = drive_n;
	wire input_settled = bus_input && (&drive_hist_reg);
	wire byte_stable = (cap_d_reg == cap_now);
	// identical back-to-back bytes merge into one
	logic [BUS_W+1:0] last_take_reg;
	wire byte_new = (cap_now != last_take_reg);
	wire take = input_settled && pulse_n && byte_stable && byte_new;
	wire is_mode = take && mode_sel;
	wire is_addr = take && !mode_sel && adn_sel;
	wire is_data = take && !mode_sel && !adn_sel;
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			last_take_reg <= '0;
		else if (take)
			last_take_reg <= cap_now;
	end

	// ----------------------------------------
	// mode, address and data holding
	// ----------------------------------------
	logic [7:0] mode_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [WORD_W-1:0] data_reg;
	// address bytes shift in low after high; data bytes likewise
	wire [ADDR_W-1:0] addr_next = {addr_reg[ADDR_W-9:0], bus_in};
	wire [WORD_W-1:0] data_next = {data_reg[WORD_W-9:0], bus_in};
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_reg <= '0;
			addr_reg <= '0;
			data_reg <= '0;
		end else begin
			if (is_mode)
				mode_reg <= bus_in;
			if (is_addr)
				addr_reg <= addr_next;
			if (is_data)
				data_reg <= data_next;
		end
	end

	// ----------------------------------------
	// security bits, one-time sticky
	// ----------------------------------------
	// held in flops here; reset brings back the blank state
	logic user_lock_reg;
	logic test_open_reg;
	logic verify_lock_reg;
	wire pulse_done;
	wire sec_user_set = pulse_done && (mode_reg == MODE_SEC_USER);
	wire sec_test_set = pulse_done && (mode_reg == MODE_SEC_TEST);
	wire sec_verify_set = pulse_done && (mode_reg == MODE_SEC_VERIFY);
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			user_lock_reg <= SEC_USER_LOCK_RST;
			test_open_reg <= SEC_TEST_OPEN_RST;
			verify_lock_reg <= SEC_VERIFY_LOCK_RST;
		end else begin
			// only ever set, never cleared
			user_lock_reg <= user_lock_reg | sec_user_set;
			test_open_reg <= test_open_reg | sec_test_set;
			verify_lock_reg <= verify_lock_reg | sec_verify_set;
		end
	end

	// ----------------------------------------
	// programming pulse timer
	// ----------------------------------------
	opp_state_t state_reg;
	opp_state_t state_next;
	logic [PULSE_CNT_W-1:0] cnt_reg;
	// count saturates at PULSE_MIN_CYC - 1, so a long pulse cannot wrap
	wire pulse_fall = pulse_n_d_reg && !pulse_n && bus_input;
	wire pulse_long = (cnt_reg >= PULSE_CNT_W'(PULSE_MIN_CYC - 1));
	wire is_write = (mode_reg == MODE_WRITE) || (mode_reg == MODE_TEST_AREA);
	wire test_area = (mode_reg == MODE_TEST_AREA);
	// user-area writes blocked by user lock; test area only when opened
	wire write_ok = test_area ? test_open_reg : !user_lock_reg;
	assign pulse_done = (state_reg == ST_PULSE) && pulse_n && pulse_long;
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (pulse_fall)
					state_next = ST_PULSE;
			end
			ST_PULSE: begin
				if (pulse_n)
					state_next = ST_DONE;
			end
			ST_DONE: begin
				state_next = ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			if (state_reg != ST_PULSE)
				cnt_reg <= '0;
			else if (!pulse_long)
				cnt_reg <= cnt_reg + 1'b1;
		end
	end

	// ----------------------------------------
	// memory strobe and read-back
	// ----------------------------------------
	// a write needs a full pulse, a write mode and an open area
	// bus enable below follows the synced strobe, one flop later
	wire we_next = pulse_done && is_write && write_ok;
	wire rd_en = !drive_n && (mode_reg == MODE_READ) && !verify_lock_reg;
	// low byte when address/data select high, else high byte
	wire [BUS_W-1:0] rd_byte = adn_sel ? mem_rdata_i[7:0] : mem_rdata_i[15:8];
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mem_we_o <= 1'b0;
			mem_test_o <= 1'b0;
			mem_addr_o <= '0;
			mem_wdata_o <= '0;
			io_o <= '0;
			io_oe_o <= '0;
			user_lock_o <= SEC_USER_LOCK_RST;
			test_open_o <= SEC_TEST_OPEN_RST;
			verify_lock_o <= SEC_VERIFY_LOCK_RST;
		end else begin
			mem_we_o <= we_next;
			mem_test_o <= test_area;
			mem_addr_o <= addr_reg;
			mem_wdata_o <= data_reg;
			io_o <= rd_en ? rd_byte : '0;
			io_oe_o <= {BUS_W{!drive_n}};
			user_lock_o <= user_lock_reg;
			test_open_o <= test_open_reg;
			verify_lock_o <= verify_lock_reg;
		end
	end

endmodule

// >>> pkg/opp_pkg.sv
// constants and types for the otp parallel programming port
package opp_pkg;

	localparam int unsigned BUS_W = 8;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned ADDR_W = 15; // 32k words
	localparam int unsigned CLK_HZ = 20000000;
	// least programming pulse, in microseconds
	localparam int unsigned PULSE_MIN_US = 100;
	localparam int unsigned PULSE_MIN_CYC = (PULSE_MIN_US * (CLK_HZ / 1000000));
	localparam int unsigned PULSE_CNT_W = 12;
	// cycles the bus must stay an input before a byte is taken again
	localparam int unsigned TURN_SETTLE_CYC = 3;
	// pin synchroniser reset: bus low, both strobes at their idle high level
	localparam logic [BUS_W+3:0] PIN_SYNC_RST = 12'h00c;
	// mode byte commands, arbitrary encodings
	localparam logic [7:0] MODE_READ = 8'h01;
	localparam logic [7:0] MODE_WRITE = 8'h02;
	localparam logic [7:0] MODE_SEC_USER = 8'h10;
	localparam logic [7:0] MODE_SEC_TEST = 8'h11;
	localparam logic [7:0] MODE_SEC_VERIFY = 8'h12;
	localparam logic [7:0] MODE_TEST_AREA = 8'h20;
	// blank-device security state: user prog on, test prog off, verify on
	localparam logic SEC_USER_LOCK_RST = 1'b0;
	localparam logic SEC_TEST_OPEN_RST = 1'b0;
	localparam logic SEC_VERIFY_LOCK_RST = 1'b0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_PULSE = 3'b010,
		ST_DONE = 3'b100
	} opp_state_t;

endpackage

// >>> tb/opp_port_sva.sv
// assertions on the otp programming port pins
`timescale 1ns/1ps
module opp_port_sva (
	input logic ref_clk_i,
	input logic rst_i,
	input logic bus_drive_n_i,
	input logic program_pulse_n_i,
	input logic [7:0] io_o,
	input logic [7:0] io_oe_o,
	input logic mem_we_o,
	input logic mem_test_o,
	input logic user_lock_o,
	input logic test_open_o,
	input logic verify_lock_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	sequence drive_held; !bus_drive_n_i [*4]; endsequence
	sequence lock_held; verify_lock_o [*2]; endsequence
	sequence input_held; bus_drive_n_i [*4]; endsequence
	a_oe_off_input: assert property (input_held |-> io_oe_o == 8'h00)
		else $error("bus driven while input");
	a_oe_on_drive: assert property (drive_held |-> io_oe_o == 8'hff)
		else $error("bus not driven");
	a_read_locked_zero: assert property (lock_held |-> io_o == 8'h00)
		else $error("read leaked");
	a_we_one_cycle: assert property (mem_we_o |=> !mem_we_o)
		else $error("strobe too long");
	a_we_after_pulse: assert property (mem_we_o |-> !$past(program_pulse_n_i, 8))
		else $error("strobe without pulse");
	a_user_lock_blocks: assert property (mem_we_o && !mem_test_o |-> !user_lock_o)
		else $error("write past user lock");
	a_test_area_closed: assert property (mem_we_o && mem_test_o |-> test_open_o)
		else $error("test write while closed");
	a_locks_stay_set: assert property ((~{user_lock_o, test_open_o, verify_lock_o}
		& $past({user_lock_o, test_open_o, verify_lock_o})) == 3'b000)
		else $error("lock cleared");
	a_blank_state: assert property ($fell(rst_i) |->
		{user_lock_o, test_open_o, verify_lock_o} == 3'b000)
		else $error("not blank");
endmodule
bind opp_port opp_port_sva chk_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
	.bus_drive_n_i(bus_drive_n_i), .program_pulse_n_i(program_pulse_n_i), .io_o(io_o),
	.io_oe_o(io_oe_o), .mem_we_o(mem_we_o), .mem_test_o(mem_test_o),
	.user_lock_o(user_lock_o), .test_open_o(test_open_o), .verify_lock_o(verify_lock_o));

// >>> tb/opp_prog_model.sv
// programmer model driving the port pins
`timescale 1ns/1ps
module opp_prog_model (
	input wire logic clk_i,
	output logic [7:0] pd_o,
	output logic pen_o,
	output logic drv_n_o,
	output logic pls_n_o,
	output logic mode_o,
	output logic ad_o
);
	initial begin
		{pd_o, pen_o, drv_n_o, pls_n_o, mode_o, ad_o} = 13'h1f1f;
	end
	// one byte held past the sync lag
	task automatic put(input logic m, input logic a, input logic [7:0] b);
		@(negedge clk_i);
		{mode_o, ad_o, pd_o, pen_o} = {m, a, b, 1'b1};
		repeat (5) @(negedge clk_i);
	endtask
	// mode, address, data, then pulse with bus input
	task automatic write(input logic [7:0] md, input logic [15:0] a, input logic [15:0] d,
		input int len);
		put(1'b1, 1'b0, md);
		put(1'b0, 1'b1, a[15:8]);
		put(1'b0, 1'b1, a[7:0]);
		put(1'b0, 1'b0, d[15:8]);
		put(1'b0, 1'b0, d[7:0]);
		pls_n_o = 1'b0;
		repeat (len) @(negedge clk_i);
		pls_n_o = 1'b1;
		repeat (8) @(negedge clk_i);
	endtask
	// direction change; released lines show inverse data
	task automatic turn(input logic dn, input logic a);
		@(negedge clk_i);
		{drv_n_o, pen_o, ad_o} = {dn, dn, a};
		repeat (4) @(negedge clk_i);
	endtask
endmodule

// >>> tb/test_otp_parallel_programming_port.sv
// self-checking bench for the otp programming port
`timescale 1ns/1ps
module test_otp_parallel_programming_port;
	import opp_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] pd, io_w, io_o, oe;
	logic pen, dn, pn, md, ad, we, tst, ul, top, vl, wt;
	logic [14:0] addr, wa;
	logic [15:0] wdat, wd;
	int bad_count = 0;
	int compares = 0;
	int nwe = 0;
	assign io_w = (oe & io_o) | (~oe & (pen ? pd : ~pd));
	always @(posedge ref_clk_i) if (we === 1'b1) {nwe, wa, wd, wt} <= {nwe + 1, addr, wdat, tst};
	opp_prog_model prog_u (.clk_i(ref_clk_i), .pd_o(pd), .pen_o(pen), .drv_n_o(dn),
		.pls_n_o(pn), .mode_o(md), .ad_o(ad));
	opp_port dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .io_i(io_w), .io_o(io_o),
		.io_oe_o(oe), .bus_drive_n_i(dn), .program_pulse_n_i(pn), .mode_sel_i(md),
		.addr_not_data_sel_i(ad), .mem_we_o(we), .mem_test_o(tst), .mem_addr_o(addr),
		.mem_wdata_o(wdat), .mem_rdata_i({~addr[7:0], addr[7:0]}), .user_lock_o(ul),
		.test_open_o(top), .verify_lock_o(vl));
	task automatic check(input string s, input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic close_out();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic t_write();
		int n;
		n = nwe;
		prog_u.write(MODE_WRITE, 16'h8123, 16'hbeef, PULSE_MIN_CYC + 1);
		check("we", nwe - n, 1);
		check("addr", wa, 16'h0123);
		check("data", wd, 16'hbeef);
		check("area", wt, 0);
		prog_u.write(MODE_WRITE, 16'h0456, 16'h1177, PULSE_MIN_CYC - 1);
		check("short", nwe - n, 1);
		$display("t_write done");
	endtask
	task automatic t_read(input logic [15:0] e);
		prog_u.put(1'b1, 1'b0, MODE_READ);
		prog_u.put(1'b0, 1'b1, 8'h12);
		prog_u.put(1'b0, 1'b1, 8'h34);
		prog_u.turn(1'b0, 1'b1);
		check("oe", oe, 8'hff);
		check("low", io_w, e[7:0]);
		prog_u.turn(1'b0, 1'b0);
		check("high", io_w, e[15:8]);
		prog_u.turn(1'b1, 1'b1);
		check("oe off", oe, 8'h00);
		$display("t_read done");
	endtask
	task automatic t_locks();
		logic [7:0] m [6] = '{MODE_TEST_AREA, MODE_SEC_TEST, MODE_TEST_AREA,
			MODE_SEC_USER, MODE_WRITE, MODE_SEC_VERIFY};
		int w [6] = '{0, 0, 1, 1, 1, 1};
		logic [2:0] f [6] = '{0, 2, 2, 6, 6, 7};
		int n;
		n = nwe;
		for (int i = 0; i < 6; i++) begin
			prog_u.write(m[i], 16'h0042, 16'h5aa5, PULSE_MIN_CYC + 1);
			check("writes", nwe - n, w[i]);
			check("locks", {ul, top, vl}, f[i]);
		end
		check("test area", wt, 1);
		check("tdata", wd, 16'h5aa5);
		$display("t_locks done");
	endtask
	initial forever #25 ref_clk_i = ~ref_clk_i;
	initial begin
		repeat (60000) @(posedge ref_clk_i);
		bad_count++;
		close_out();
	end
	initial begin
		repeat (4) @(negedge ref_clk_i);
		rst_i = 1'b0;
		check("blank", {ul, top, vl}, 0);
		t_write();
		t_read(16'hcb34);
		t_locks();
		t_read(16'h0000);
		close_out();
	end
endmodule
